// ===== hdl/arc_pkg.sv
// package of constants and types for the auto reclose sequencer
package arc_pkg;

  // ------------------------------------------------------------
  // bus register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ARC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] ARC_OFS_ACT     = 8'h04;
  localparam logic [7:0] ARC_OFS_MAXST   = 8'h08;
  localparam logic [7:0] ARC_OFS_RECL    = 8'h0C;
  localparam logic [7:0] ARC_OFS_CBTO    = 8'h10;
  localparam logic [7:0] ARC_OFS_DYNBLK  = 8'h14;
  localparam logic [7:0] ARC_OFS_MANCL   = 8'h18;
  localparam logic [7:0] ARC_OFS_CLOSE   = 8'h1C;
  localparam logic [7:0] ARC_OFS_DT1PH   = 8'h20;  // four words, 0x20..0x2C
  localparam logic [7:0] ARC_OFS_DT3PH   = 8'h30;  // four words, 0x30..0x3C
  localparam logic [7:0] ARC_OFS_STATUS  = 8'h40;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int ARC_CTRL_OP_BIT  = 0;
  localparam int ARC_CTRL_SRC_BIT = 1;
  localparam int ARC_CTRL_CYC_LSB = 4;
  localparam int ARC_CTRL_CYC_W   = 3;

  localparam logic [31:0] ARC_CTRL_RESET = 32'h0000_0000;
  localparam int          ARC_TMR_W      = 16;
  localparam logic [15:0] ARC_TMR_RESET  = 16'h0064;   // 100 ms default limit
  localparam logic [2:0]  ARC_MAX_SHOTS  = 3'h4;

  // ------------------------------------------------------------
  // millisecond tick from the 125 MHz clock
  // ------------------------------------------------------------
  localparam int ARC_CLK_HZ     = 125_000_000;
  localparam int ARC_TICK_US    = 1000;
  localparam int ARC_TICK_CYC   = (ARC_CLK_HZ / 1_000_000) * ARC_TICK_US;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ARC_IDLE    = 3'b000,
    ARC_ACTION  = 3'b001,
    ARC_TRIPPED = 3'b010,
    ARC_DEAD    = 3'b011,
    ARC_CBWAIT  = 3'b100,
    ARC_RECLAIM = 3'b101,
    ARC_DYNBLK  = 3'b110
  } arc_state_t;

endpackage

// ===== hdl/arc_seq.sv
// auto reclose sequencer with ahb-lite register slave
`timescale 1ns/1ns
module arc_seq
  import arc_pkg::*;
#(
  parameter int TICK_CYC = ARC_TICK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // protection and breaker side
  input  wire logic        protection_start_in,
  input  wire logic        reclose_trigger_in,
  input  wire logic        three_phase_trip_in,
  input  wire logic        breaker_open_in,
  input  wire logic        breaker_ready_in,
  input  wire logic        block_in,
  input  wire logic        device_block_in,
  input  wire logic        manual_close_in,
  output logic             close_cmd_out,
  output logic             in_progress_out,
  output logic             dyn_blocked_out
);

  localparam int TW = ARC_TMR_W;

  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    // settings
    logic [31:0]        ctrl;
    logic [TW-1:0]      action_time_limit;
    logic [TW-1:0]      start_signal_max_time;
    logic [TW-1:0]      reclaim_time;
    logic [TW-1:0]      breaker_supervision_time;
    logic [TW-1:0]      dynamic_blocking_time;
    logic [TW-1:0]      manual_close_time;
    logic [TW-1:0]      close_pulse_time;
    logic [4*TW-1:0]    dt1ph;
    logic [4*TW-1:0]    dt3ph;
    // bus data phase
    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic [31:0]        rdata;
    // sequencer
    arc_state_t         state;
    logic [2:0]         shot;
    logic               three_ph;
    logic [TW-1:0]      seq_tmr;   // per-state timer
    logic [TW-1:0]      max_tmr;   // start-signal max timer
    logic [TW-1:0]      close_tmr;
    logic [TW-1:0]      man_tmr;
    logic               close_cmd;
    logic               in_prog;
    logic               dyn_blk;
  } arc_seq_st_t;

  arc_seq_st_t st_ff;
  arc_seq_st_t nxt_st;
  logic        tick;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // dead-time setting lookup, used for both phase sets
  function automatic logic [TW-1:0] dt_pick(input logic [4*TW-1:0] set, input logic [2:0] shot);
    logic [1:0] idx;
    idx     = shot[1:0] - 2'h1;
    dt_pick = set[idx*TW +: TW];
  endfunction

  // saturating timer step on the ms tick
  function automatic logic [TW-1:0] tmr_step(input logic [TW-1:0] t, input logic tk);
    tmr_step = (tk && t != {TW{1'b1}}) ? t + {{(TW-1){1'b0}}, 1'b1} : t;
  endfunction

  arc_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic       op_on;
  logic       src_open;
  logic [2:0] cyc_set;
  logic       inhibit;
  logic       addr_ph;
  logic [TW-1:0] dt_now;

  always_comb begin
    nxt_st   = st_ff;
    op_on    = st_ff.ctrl[ARC_CTRL_OP_BIT];
    src_open = st_ff.ctrl[ARC_CTRL_SRC_BIT];
    cyc_set  = st_ff.ctrl[ARC_CTRL_CYC_LSB +: ARC_CTRL_CYC_W];
    if (cyc_set > ARC_MAX_SHOTS) begin
      cyc_set = ARC_MAX_SHOTS;
    end
    dt_now = st_ff.three_ph ? dt_pick(st_ff.dt3ph, st_ff.shot) : dt_pick(st_ff.dt1ph, st_ff.shot);

    // bus: write data phase lands one cycle after the address phase
    addr_ph = hsel && hready && htrans[1];
    nxt_st.wr_pend = addr_ph && hwrite;
    nxt_st.wr_addr = haddr;
    if (st_ff.wr_pend) begin
      case (st_ff.wr_addr)
        ARC_OFS_CTRL:   nxt_st.ctrl = hwdata;
        ARC_OFS_ACT:    nxt_st.action_time_limit = hwdata[TW-1:0];
        ARC_OFS_MAXST:  nxt_st.start_signal_max_time = hwdata[TW-1:0];
        ARC_OFS_RECL:   nxt_st.reclaim_time = hwdata[TW-1:0];
        ARC_OFS_CBTO:   nxt_st.breaker_supervision_time = hwdata[TW-1:0];
        ARC_OFS_DYNBLK: nxt_st.dynamic_blocking_time = hwdata[TW-1:0];
        ARC_OFS_MANCL:  nxt_st.manual_close_time = hwdata[TW-1:0];
        ARC_OFS_CLOSE:  nxt_st.close_pulse_time = hwdata[TW-1:0];
        default: begin
          if (st_ff.wr_addr[7:4] == ARC_OFS_DT1PH[7:4]) begin
            nxt_st.dt1ph[st_ff.wr_addr[3:2]*TW +: TW] = hwdata[TW-1:0];
          end else if (st_ff.wr_addr[7:4] == ARC_OFS_DT3PH[7:4]) begin
            nxt_st.dt3ph[st_ff.wr_addr[3:2]*TW +: TW] = hwdata[TW-1:0];
          end
        end
      endcase
    end
    // read data registered at the address phase; unmapped reads zero
    if (addr_ph && !hwrite) begin
      case (haddr)
        ARC_OFS_CTRL:   nxt_st.rdata = st_ff.ctrl;
        ARC_OFS_ACT:    nxt_st.rdata = 32'(st_ff.action_time_limit);
        ARC_OFS_MAXST:  nxt_st.rdata = 32'(st_ff.start_signal_max_time);
        ARC_OFS_RECL:   nxt_st.rdata = 32'(st_ff.reclaim_time);
        ARC_OFS_CBTO:   nxt_st.rdata = 32'(st_ff.breaker_supervision_time);
        ARC_OFS_DYNBLK: nxt_st.rdata = 32'(st_ff.dynamic_blocking_time);
        ARC_OFS_MANCL:  nxt_st.rdata = 32'(st_ff.manual_close_time);
        ARC_OFS_CLOSE:  nxt_st.rdata = 32'(st_ff.close_pulse_time);
        ARC_OFS_STATUS: nxt_st.rdata = {21'h000000, st_ff.man_tmr != '0, st_ff.three_ph,
                                        st_ff.shot, st_ff.state, st_ff.dyn_blk, st_ff.in_prog,
                                        st_ff.close_cmd};
        default: begin
          if (haddr[7:4] == ARC_OFS_DT1PH[7:4]) begin
            nxt_st.rdata = 32'(st_ff.dt1ph[haddr[3:2]*TW +: TW]);
          end else if (haddr[7:4] == ARC_OFS_DT3PH[7:4]) begin
            nxt_st.rdata = 32'(st_ff.dt3ph[haddr[3:2]*TW +: TW]);
          end else begin
            nxt_st.rdata = 32'h0000_0000;
          end
        end
      endcase
    end

    // manual close hold-off counts down on the tick
    if (manual_close_in) begin
      nxt_st.man_tmr = st_ff.manual_close_time;
    end else if (tick && st_ff.man_tmr != '0) begin
      nxt_st.man_tmr = st_ff.man_tmr - {{(TW-1){1'b0}}, 1'b1};
    end

    // close pulse: timed, dropped at once by any trip
    if (st_ff.close_cmd) begin
      nxt_st.close_tmr = tmr_step(st_ff.close_tmr, tick);
      if (reclose_trigger_in || st_ff.close_tmr >= st_ff.close_pulse_time) begin
        nxt_st.close_cmd = 1'b0;
      end
    end

    nxt_st.seq_tmr = tmr_step(st_ff.seq_tmr, tick);
    nxt_st.max_tmr = tmr_step(st_ff.max_tmr, tick);

    inhibit = !op_on || block_in || device_block_in || cyc_set == 3'h0 || st_ff.man_tmr != '0;

    case (st_ff.state)
      ARC_IDLE: begin
        nxt_st.shot     = 3'h1;
        nxt_st.three_ph = 1'b0;
        nxt_st.seq_tmr  = '0;
        if (reclose_trigger_in) begin
          nxt_st.state   = ARC_TRIPPED;
          nxt_st.in_prog = 1'b1;
          nxt_st.max_tmr = '0;
        end else if (protection_start_in) begin
          nxt_st.state = ARC_ACTION;
        end
      end
      ARC_ACTION: begin
        if (reclose_trigger_in) begin
          nxt_st.state   = ARC_TRIPPED;
          nxt_st.in_prog = 1'b1;
          nxt_st.max_tmr = '0;
          nxt_st.seq_tmr = '0;
        end else if (st_ff.seq_tmr >= st_ff.action_time_limit) begin
          nxt_st.state   = ARC_DYNBLK;
          nxt_st.seq_tmr = '0;
        end else if (!protection_start_in) begin
          nxt_st.state = ARC_IDLE;
        end
      end
      ARC_TRIPPED: begin
        if (three_phase_trip_in) begin
          nxt_st.three_ph = 1'b1;
        end
        nxt_st.seq_tmr = '0;
        if (src_open ? breaker_open_in : !reclose_trigger_in) begin
          nxt_st.state = ARC_DEAD;
        end else if (st_ff.max_tmr >= st_ff.start_signal_max_time) begin
          nxt_st.state = ARC_DYNBLK;
        end
      end
      ARC_DEAD: begin
        if (st_ff.seq_tmr >= dt_now) begin
          nxt_st.state   = ARC_CBWAIT;
          nxt_st.seq_tmr = '0;
        end
      end
      ARC_CBWAIT: begin
        if (breaker_ready_in) begin
          nxt_st.state     = ARC_RECLAIM;
          nxt_st.close_cmd = 1'b1;
          nxt_st.close_tmr = '0;
          nxt_st.seq_tmr   = '0;
        end else if (st_ff.seq_tmr >= st_ff.breaker_supervision_time) begin
          nxt_st.state   = ARC_DYNBLK;
          nxt_st.seq_tmr = '0;
        end
      end
      ARC_RECLAIM: begin
        if (reclose_trigger_in) begin
          nxt_st.close_cmd = 1'b0;
          nxt_st.max_tmr   = '0;
          nxt_st.seq_tmr   = '0;
          if (st_ff.shot >= cyc_set) begin
            nxt_st.state = ARC_DYNBLK;
          end else begin
            nxt_st.shot  = st_ff.shot + 3'h1;
            nxt_st.state = ARC_TRIPPED;
          end
        end else if (st_ff.seq_tmr >= st_ff.reclaim_time) begin
          nxt_st.state   = ARC_IDLE;
          nxt_st.in_prog = 1'b0;
        end
      end
      ARC_DYNBLK: begin
        nxt_st.in_prog   = 1'b0;
        nxt_st.close_cmd = 1'b0;
        if (st_ff.seq_tmr >= st_ff.dynamic_blocking_time) begin
          nxt_st.state = ARC_IDLE;
        end
      end
      default: begin
        nxt_st.state = ARC_IDLE;
      end
    endcase

    // block conditions override everything and drop the sequence
    if (inhibit) begin
      nxt_st.state     = ARC_IDLE;
      nxt_st.in_prog   = 1'b0;
      nxt_st.close_cmd = 1'b0;
    end
    // entering dynamic block ends the run in the same edge, not one later
    if (nxt_st.state == ARC_DYNBLK) begin
      nxt_st.in_prog   = 1'b0;
      nxt_st.close_cmd = 1'b0;
    end
    nxt_st.dyn_blk = (nxt_st.state == ARC_DYNBLK);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff                          <= '0;
      st_ff.ctrl                     <= ARC_CTRL_RESET;
      st_ff.action_time_limit        <= ARC_TMR_RESET;
      st_ff.start_signal_max_time    <= ARC_TMR_RESET;
      st_ff.reclaim_time             <= ARC_TMR_RESET;
      st_ff.breaker_supervision_time <= ARC_TMR_RESET;
      st_ff.dynamic_blocking_time    <= ARC_TMR_RESET;
      st_ff.manual_close_time        <= ARC_TMR_RESET;
      st_ff.close_pulse_time         <= ARC_TMR_RESET;
      st_ff.dt1ph                    <= {4{ARC_TMR_RESET}};
      st_ff.dt3ph                    <= {4{ARC_TMR_RESET}};
      st_ff.state                    <= ARC_IDLE;
      st_ff.shot                     <= 3'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops, hreadyout and hresp tied off; zero-wait, always okay
  assign hrdata          = st_ff.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign close_cmd_out   = st_ff.close_cmd;
  assign in_progress_out = st_ff.in_prog;
  assign dyn_blocked_out = st_ff.dyn_blk;

endmodule

// ===== hdl/arc_tick.sv
// millisecond tick generator for the sequencer timers
`timescale 1ns/1ns
module arc_tick
  import arc_pkg::*;
#(
  parameter int TICK_CYC = ARC_TICK_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } arc_tick_st_t;

  arc_tick_st_t st_ff;
  arc_tick_st_t nxt_st;

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  // one-cycle pulse every TICK_CYC clocks
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 32'(TICK_CYC - 1)) begin
      nxt_st.cnt  = 32'h0000_0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

// ===== testbench/arc_breaker_model.sv
// breaker status model standing behind the sequencer
`timescale 1ns/1ns
module arc_breaker_model #(
  parameter int READY_DLY = 6
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic trip,
  input  wire logic close_cmd,
  input  wire logic open_en,
  input  wire logic ready_en,
  output logic      breaker_open,
  output logic      breaker_ready
);
  int dly;
  // poles open on a trip when open_en is set, close on the close command; ready comes late on purpose
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      breaker_open  <= 1'h0;
      breaker_ready <= 1'h0;
      dly           <= READY_DLY;
    end else begin
      if (close_cmd)
        breaker_open <= 1'h0;
      else if (trip && open_en)
        breaker_open <= 1'h1;
      dly           <= ready_en ? (dly > 0 ? dly - 1 : 0) : READY_DLY;
      breaker_ready <= ready_en && dly == 0;
    end
  end
endmodule

// ===== testbench/arc_seq_asserts.sv
// port-level checks of the auto reclose sequencer
`timescale 1ns/1ns
module arc_seq_asserts #(
  parameter int TICK_CYC = 125000
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       reclose_trigger_in,
  input wire logic       breaker_ready_in,
  input wire logic       block_in,
  input wire logic       device_block_in,
  input wire logic       manual_close_in,
  input wire logic       close_cmd_out,
  input wire logic       in_progress_out,
  input wire logic       dyn_blocked_out
);
  int dcnt_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // length of the running dynamic-block stretch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      dcnt_ff <= 0;
    else
      dcnt_ff <= dyn_blocked_out ? dcnt_ff + 1 : 0;
  end
  a_bus_okay: assert property (hsel && htrans[1] |=> hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_reset_quiet: assert property ($fell(rst) |-> !close_cmd_out && !in_progress_out && !dyn_blocked_out)
    else $error("outputs active after reset");
  a_block_inhibit: assert property (block_in |=> !in_progress_out && !close_cmd_out)
    else $error("sequence runs while blocked");
  a_dev_block: assert property (device_block_in |=> !in_progress_out && !close_cmd_out)
    else $error("sequence runs under device block");
  a_manual_hold: assert property (manual_close_in |=> !in_progress_out ##1 !in_progress_out)
    else $error("sequence runs in manual hold-off");
  a_close_cut: assert property (close_cmd_out && reclose_trigger_in |=> !close_cmd_out)
    else $error("close not cut by trip");
  a_close_ready: assert property ($rose(close_cmd_out) |-> $past(breaker_ready_in) && in_progress_out)
    else $error("close without ready breaker");
  a_run_cause: assert property ($rose(in_progress_out) |-> $past(reclose_trigger_in))
    else $error("run started without trip");
  a_dyn_quiet: assert property (dyn_blocked_out |-> !in_progress_out && !close_cmd_out)
    else $error("activity in dynamic block");
  a_dyn_hold: assert property ($fell(dyn_blocked_out) && !block_in && !device_block_in |-> dcnt_ff >= TICK_CYC)
    else $error("dynamic block too short");
  c_close: cover property ($rose(close_cmd_out));
  c_dyn: cover property ($rose(dyn_blocked_out));
  c_cut: cover property (close_cmd_out && reclose_trigger_in);
endmodule
bind arc_seq arc_seq_asserts #(.TICK_CYC(TICK_CYC)) u_arc_chk (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hreadyout(hreadyout), .hresp(hresp),
  .reclose_trigger_in(reclose_trigger_in), .breaker_ready_in(breaker_ready_in), .block_in(block_in),
  .device_block_in(device_block_in), .manual_close_in(manual_close_in), .close_cmd_out(close_cmd_out),
  .in_progress_out(in_progress_out), .dyn_blocked_out(dyn_blocked_out)
);

// ===== testbench/auto_reclose_sequencer_tb.sv
// self-checking bench for the auto reclose sequencer
`timescale 1ns/1ns
module auto_reclose_sequencer_tb
  import arc_pkg::*;
;
  localparam int T = 4;
  logic        core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        pst, trig, tp, bopen, brdy, blk, dblk, man, cls, run, dyn, open_en, ready_en;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, d;
  int          bad_count, n_compared, cyc, c, w, n;
  bit          ok;
  int          lim[7] = '{3, 6, 4, 3, 3, 3, 2}; // ms: act maxst reclaim cbto dynblk mancl close
  arc_seq #(.TICK_CYC(T)) dut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .protection_start_in(pst), .reclose_trigger_in(trig), .three_phase_trip_in(tp),
    .breaker_open_in(bopen), .breaker_ready_in(brdy), .block_in(blk), .device_block_in(dblk),
    .manual_close_in(man), .close_cmd_out(cls), .in_progress_out(run), .dyn_blocked_out(dyn));
  arc_breaker_model bkr (.core_clk(core_clk), .rst(rst), .trip(trig), .close_cmd(cls), .open_en(open_en),
    .ready_en(ready_en), .breaker_open(bopen), .breaker_ready(brdy));
  assign hready = hreadyout;
  // clock
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  // hang guard, far above the few thousand cycles needed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask
  // one single ahb-lite transfer, held until hready
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'h0, 32'h0, d);
    chk(d, exp);
  endtask
  task automatic trip(input logic ph3, input int len);
    @(posedge core_clk);
    trig <= 1'h1;
    tp   <= ph3;
    repeat (len) @(posedge core_clk);
    trig <= 1'h0;
    tp   <= 1'h0;
  endtask
  // bounded wait: 0 close or block, 1 close ends, 2 back to idle
  task automatic await(input int sel);
    c = 0;
    do begin
      @(posedge core_clk);
      #1 c++;
    end while (!(sel == 0 ? (cls | dyn) === 1'h1 : sel == 1 ? cls === 1'h0 : (run | dyn) === 1'h0) && c < 300);
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, bad_count);
  endtask
  task automatic results();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    {hsel, hwrite, pst, trig, tp, blk, dblk, man, open_en} = '0;
    ready_en = 1'h1;
    haddr    = 8'h0;
    htrans   = 2'h0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    rst      = 1'h1;
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    rdchk(ARC_OFS_CTRL, ARC_CTRL_RESET);
    rdchk(ARC_OFS_CLOSE, {16'h0, ARC_TMR_RESET});
    rdchk(8'h80, 32'h0);
    bus(ARC_OFS_STATUS, 1'h1, 32'hFFFF, d);
    rdchk(ARC_OFS_STATUS, 32'h0000_0040);
    for (int i = 0; i < 7; i++) begin
      bus(ARC_OFS_ACT + 8'(4 * i), 1'h1, 32'hABCD0000 | 32'(lim[i]), d);
      rdchk(ARC_OFS_ACT + 8'(4 * i), 32'(lim[i]));
    end
    for (int i = 0; i < 4; i++) begin
      bus(ARC_OFS_DT1PH + 8'(4 * i), 1'h1, 32'(i + 2), d);
      bus(ARC_OFS_DT3PH + 8'(4 * i), 1'h1, 32'(7 - i), d);
    end
    done("registers");
    // single shot twice: a later fault starts over at shot one
    bus(ARC_OFS_CTRL, 1'h1, 32'h11, d);
    for (int r = 0; r < 2; r++) begin
      trip(1'h0, 3);
      await(0);
      rng(c, 2 * T, 3 * T + 4);
      chk(run, 1'h1);
      await(1);
      w = c;
      rng(w, T + 2, 2 * T + 1);
      await(2);
      rng(w + c, 3 * T + 2, 4 * T + 1);
    end
    done("single shot");
    // cycle settings 0 to 5; first trip three-phase, the rest single-phase
    for (int cy = 0; cy < 6; cy++) begin
      bus(ARC_OFS_CTRL, 1'h1, 32'(cy * 16 + 1), d);
      n = 0;
      do begin
        trip(n == 0, 3);
        await(0);
        ok = cls === 1'h1;
        if (ok) begin
          rng(c, (7 - n) * T, (8 - n) * T + 4);
          n++;
          repeat (2) @(posedge core_clk);
        end
      end while (ok && n < 6);
      chk(n, cy > 4 ? 4 : cy);
      chk(dyn, cy > 0);
      await(2);
    end
    done("shot counts");
    // breaker never ready
    bus(ARC_OFS_CTRL, 1'h1, 32'h11, d);
    ready_en <= 1'h0;
    trip(1'h0, 3);
    await(0);
    chk(dyn, 1'h1);
    rng(c, 3 * T + 5, 5 * T + 3);
    await(2);
    rng(c, 2 * T + 2, 3 * T + 1);
    ready_en <= 1'h1;
    // long enough to outlast the max timer, short enough to catch the block
    trip(1'h0, 28);
    await(0);
    chk(dyn, 1'h1);
    await(2);
    done("supervision");
    // breaker-open start, then an open that never comes
    bus(ARC_OFS_CTRL, 1'h1, 32'h13, d);
    open_en <= 1'h1;
    trip(1'h0, 3);
    await(0);
    chk(cls, 1'h1);
    await(2);
    open_en <= 1'h0;
    trip(1'h0, 3);
    await(0);
    chk(dyn, 1'h1);
    await(2);
    done("open start");
    // pickup without trip, then pickup followed by trip
    bus(ARC_OFS_CTRL, 1'h1, 32'h11, d);
    pst <= 1'h1;
    await(0);
    chk(dyn, 1'h1);
    rng(c, 2 * T + 3, 3 * T + 2);
    pst <= 1'h0;
    await(2);
    pst <= 1'h1;
    trip(1'h0, 3);
    pst <= 1'h0;
    await(0);
    chk(cls, 1'h1);
    await(2);
    done("action time");
    // block, device block, manual hold-off and operation off each stop a trip; reclosing works again once cleared
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      blk  <= k == 0;
      dblk <= k == 1;
      man  <= k == 2;
      if (k == 3)
        bus(ARC_OFS_CTRL, 1'h1, 32'h10, d);
      trip(1'h0, 3);
      man <= 1'h0;
      repeat (3 * T) @(posedge core_clk);
      #1 chk(run | cls, 1'h0);
      blk  <= 1'h0;
      dblk <= 1'h0;
      bus(ARC_OFS_CTRL, 1'h1, 32'h11, d);
      repeat (5 * T) @(posedge core_clk);
      trip(1'h0, 3);
      await(0);
      chk(cls, 1'h1);
      await(2);
    end
    done("inhibits");
    results();
  end
endmodule
